/* include/ccb_pkg.sv */
// package of constants and types for the converter bring-up command interpreter
package ccb_pkg;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam int         CCB_FRAME_BITS   = 32;
	localparam int         CCB_OPC_BITS     = 8;
	localparam int         CCB_SRAM_BITS    = 24;
	localparam logic [1:0] CCB_PFX_CFG_WR   = 2'h3;
	localparam logic [1:0] CCB_PFX_RES_RD   = 2'h1;
	localparam logic [3:0] CCB_PFX_SRAM_WR  = 4'h9;
	localparam logic [3:0] CCB_PFX_SRAM_RD  = 4'h1;

	// ------------------------------------------------------------
	// single-byte opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] CCB_OPC_POWER_UP = 8'h88;
	localparam logic [7:0] CCB_OPC_PARTIAL  = 8'h8A;
	localparam logic [7:0] CCB_OPC_START    = 8'h8C;

	// ------------------------------------------------------------
	// register addresses and values
	// ------------------------------------------------------------
	localparam int          CCB_CFG_COUNT        = 11;
	localparam logic [5:0]  CCB_RUN_CONTROL_ADDR = 6'h14;
	localparam logic [5:0]  CCB_RES_ZERO_ADDR    = 6'h00;
	localparam logic [5:0]  CCB_CAP_RATIO_ADDR   = 6'h01;
	localparam logic [5:0]  CCB_STATUS_ADDR      = 6'h08;
	localparam logic [5:0]  CCB_RES_RATIO_ADDR   = 6'h0E;
	localparam logic [23:0] CCB_CFG_RESET        = 24'h000000;
	localparam logic [23:0] CCB_RESULT_RESET     = 24'h000000;
	localparam int          CCB_STAT_RUNNING_BIT = 20;
	localparam int          CCB_STAT_READY_BIT   = 23;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CCB_IDLE = 2'h0,
		CCB_PREP = 2'h1,
		CCB_MEAS = 2'h3
	} ccb_meas_state_t;

	typedef struct packed {
		logic [1:0]  prefix;
		logic [5:0]  addr;
		logic [23:0] data;
	} ccb_cfg_frame_t;

	// integer time-bin count and 3.21 fixed-point ratios
	typedef struct packed {
		logic [23:0] discharge_bins;
		logic [23:0] cap_ratio;
		logic [23:0] res_ratio;
	} ccb_results_t;

endpackage

/* logic/ccb_interp.sv */
// serial command interpreter for converter bring-up, with firmware SRAM
`timescale 1ns/100ps
module ccb_interp import ccb_pkg::*; #(
	parameter int SRAM_AW = 12
) (
	// system clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst,
	// serial host link
	input  wire logic                                link_sclk,
	input  wire logic                                link_select_n,
	input  wire logic                                link_mosi,
	output logic                                     link_miso,
	// configuration and control towards the converter
	output logic [CCB_CFG_COUNT-1:0][23:0]           config_words,
	output logic                                     run_bit,
	output logic                                     power_up_reset,
	output logic                                     partial_reset,
	output logic                                     meas_start,
	output ccb_meas_state_t                          meas_state,
	// results from the converter
	input  wire logic                                res_valid,
	output logic                                     res_ready,
	input  wire ccb_results_t                        res_in,
	// firmware fetch port
	input  wire logic [SRAM_AW-1:0]                  fw_addr,
	output logic [7:0]                               fw_data
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (SRAM_AW < 1 || SRAM_AW > 12) begin : g_bad_aw
		$error("SRAM_AW must lie between 1 and 12");
	end

	localparam int SRAM_DEPTH = 1 << SRAM_AW;

	// ------------------------------------------------------------
	// link domain: shift in on rising sclk
	// ------------------------------------------------------------
	logic        armed;
	logic [5:0]  bit_cnt;
	logic [31:0] shift_in;
	logic [23:0] tx;
	logic [23:0] read_word;
	logic [7:0]  sram [SRAM_DEPTH];

	// system-domain values that the answer mux reads
	ccb_results_t results;
	logic [23:0]  status_word;

	// armed is set while the frame is idle so the first edge restarts the count
	always_ff @(posedge link_sclk or posedge link_select_n) begin
		if (link_select_n) begin
			armed <= 1'b1;
		end else begin
			armed <= 1'b0;
		end
	end

	always_ff @(posedge link_sclk) begin
		if (armed) begin
			bit_cnt  <= 6'h01;
			shift_in <= {31'h0, link_mosi};
		end else begin
			if (bit_cnt != 6'h3F) begin
				bit_cnt <= bit_cnt + 6'h01;
			end
			shift_in <= {shift_in[30:0], link_mosi};
		end
	end

	// ------------------------------------------------------------
	// link domain: answer data on falling sclk
	// ------------------------------------------------------------
	// results only change while the link is idle, so this mux is stable
	always_comb begin
		read_word = 24'h000000;
		if (shift_in[5:0] == CCB_STATUS_ADDR) begin
			read_word = status_word;
		end else if (shift_in[5:0] == CCB_RES_ZERO_ADDR) begin
			read_word = results.discharge_bins;
		end else if (shift_in[5:0] == CCB_CAP_RATIO_ADDR) begin
			read_word = results.cap_ratio;
		end else if (shift_in[5:0] == CCB_RES_RATIO_ADDR) begin
			read_word = results.res_ratio;
		end
	end

	always_ff @(negedge link_sclk or posedge link_select_n) begin
		if (link_select_n) begin
			tx <= 24'h000000;
		end else if (bit_cnt == 6'(CCB_OPC_BITS) && shift_in[7:6] == CCB_PFX_RES_RD) begin
			tx <= read_word;
		end else if (bit_cnt == 6'(16) && shift_in[15:12] == CCB_PFX_SRAM_RD) begin
			tx <= {sram[shift_in[SRAM_AW-1:0]], 16'h0000};
		end else begin
			tx <= {tx[22:0], 1'b0};
		end
	end

	// ------------------------------------------------------------
	// system domain: frame end detection
	// ------------------------------------------------------------
	logic select_n_sync;
	logic select_n_prev;
	logic frame_end;
	logic link_seen_idle;

	ccb_sync #(
		.W(1)
	) u_select_sync (
		.clk     (clk),
		.rst     (rst),
		.async_in(link_select_n),
		.sync_out(select_n_sync)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			select_n_prev  <= 1'b1;
			link_seen_idle <= 1'b0;
		end else begin
			select_n_prev  <= select_n_sync;
			if (select_n_sync) begin
				link_seen_idle <= 1'b1;
			end
		end
	end

	// sclk is stopped once select is high, so shift_in and bit_cnt hold still
	assign frame_end = select_n_sync && !select_n_prev && link_seen_idle;

	// tx is cleared by the idle select; gate until that is known to have happened
	assign link_miso = link_seen_idle & tx[23];

	// ------------------------------------------------------------
	// system domain: command decode
	// ------------------------------------------------------------
	ccb_cfg_frame_t cfg_frame;
	logic           is_cfg_wr;
	logic           is_opc;
	logic           is_sram_wr;

	assign cfg_frame  = shift_in;
	assign is_cfg_wr  = frame_end && bit_cnt == 6'(CCB_FRAME_BITS) && cfg_frame.prefix == CCB_PFX_CFG_WR;
	assign is_opc     = frame_end && bit_cnt == 6'(CCB_OPC_BITS);
	assign is_sram_wr = frame_end && bit_cnt == 6'(CCB_SRAM_BITS) && shift_in[23:20] == CCB_PFX_SRAM_WR;

	// single-cycle command pulses; any other length or prefix falls through
	always_ff @(posedge clk) begin
		if (rst) begin
			power_up_reset <= 1'b0;
			partial_reset  <= 1'b0;
			meas_start     <= 1'b0;
		end else begin
			power_up_reset <= is_opc && shift_in[7:0] == CCB_OPC_POWER_UP;
			partial_reset  <= is_opc && shift_in[7:0] == CCB_OPC_PARTIAL;
			meas_start     <= is_opc && shift_in[7:0] == CCB_OPC_START;
		end
	end

	// ------------------------------------------------------------
	// configuration registers and run bit
	// ------------------------------------------------------------
	// only rst or a power-up reset clears the loaded configuration
	always_ff @(posedge clk) begin
		if (rst || power_up_reset) begin
			config_words <= {CCB_CFG_COUNT{CCB_CFG_RESET}};
			run_bit      <= 1'b0;
		end else if (is_cfg_wr) begin
			if (cfg_frame.addr < 6'(CCB_CFG_COUNT)) begin
				config_words[cfg_frame.addr[3:0]] <= cfg_frame.data;
			end else if (cfg_frame.addr == CCB_RUN_CONTROL_ADDR) begin
				run_bit <= cfg_frame.data[0];
			end
		end
	end

	// ------------------------------------------------------------
	// firmware SRAM
	// ------------------------------------------------------------
	// contents survive both resets; the host reloads after a power-up reset
	always_ff @(posedge clk) begin
		if (is_sram_wr) begin
			sram[shift_in[SRAM_AW+7:8]] <= shift_in[7:0];
		end
	end

	assign fw_data = sram[fw_addr];

	// ------------------------------------------------------------
	// measurement state
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || power_up_reset) begin
			meas_state <= CCB_IDLE;
		end else begin
			case (meas_state)
				CCB_IDLE: begin
					if (partial_reset) begin
						meas_state <= CCB_PREP;
					end
				end
				CCB_PREP: begin
					if (meas_start) begin
						meas_state <= CCB_MEAS;
					end
				end
				CCB_MEAS: begin
					if (partial_reset) begin
						meas_state <= CCB_PREP;
					end
				end
				default: begin
					meas_state <= CCB_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// results and status
	// ------------------------------------------------------------
	logic         results_loaded;
	logic         res_take;

	// results may only move while no frame is open on the link
	assign res_ready = select_n_sync && select_n_prev && meas_state == CCB_MEAS;
	assign res_take  = res_valid && res_ready;

	always_ff @(posedge clk) begin
		if (rst || power_up_reset) begin
			results <= {3{CCB_RESULT_RESET}};
		end else if (res_take) begin
			results <= res_in;
		end
	end

	// a result arriving with a partial reset still marks ready
	always_ff @(posedge clk) begin
		if (rst || power_up_reset) begin
			results_loaded <= 1'b0;
		end else if (res_take) begin
			results_loaded <= 1'b1;
		end else if (partial_reset) begin
			results_loaded <= 1'b0;
		end
	end

	always_comb begin
		status_word = 24'h000000;
		status_word[CCB_STAT_RUNNING_BIT] = meas_state == CCB_MEAS;
		status_word[CCB_STAT_READY_BIT]   = results_loaded;
	end

endmodule

/* logic/ccb_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module ccb_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	if (W < 1) begin : g_bad_w
		$error("W must be at least 1");
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1   <= '1;
			sync_out <= '1;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

/* tb/ccb_host.sv */
// host controller model on the serial link
`timescale 1ns/100ps
module ccb_host (
	// link
	output logic        link_sclk,
	output logic        link_select_n,
	output logic        link_mosi,
	input  wire logic   link_miso,
	// captured answer
	output logic        rd_stb,
	output logic [31:0] rd_word
);
	initial begin
		link_sclk = 1'b0;
		link_select_n = 1'b1;
		link_mosi = 1'b0;
		rd_stb = 1'b0;
		rd_word = '0;
	end
	// frame is left aligned in w; the clock stands still between frames
	task automatic xfer(input logic [31:0] w, input int n, input logic rd);
		link_select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			link_mosi = w[31-i];
			#15 link_sclk = 1'b1;
			rd_word = {rd_word[30:0], link_miso};
			#15 link_sclk = 1'b0;
		end
		#15 link_select_n = 1'b1;
		// released line must not keep showing the last bit
		link_mosi = ~link_mosi;
		rd_stb = rd;
		#100 rd_stb = 1'b0;
	endtask
endmodule

/* tb/ccb_sva.sv */
// port checker for the bring-up command interpreter
`timescale 1ns/100ps
module ccb_sva import ccb_pkg::*; (
	// clock and reset
	input wire logic                           clk,
	input wire logic                           rst,
	// watched ports
	input wire logic                           link_select_n,
	input wire logic [CCB_CFG_COUNT-1:0][23:0] config_words,
	input wire logic                           run_bit,
	input wire logic                           power_up_reset,
	input wire logic                           partial_reset,
	input wire logic                           meas_start,
	input wire ccb_meas_state_t                meas_state,
	input wire logic                           res_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_cmd;
		power_up_reset || partial_reset || meas_start;
	endsequence
	sequence s_meas;
		meas_state == CCB_MEAS;
	endsequence
	a_pulse_single: assert property (s_cmd |=> !(power_up_reset || partial_reset || meas_start))
		else $error("command pulse longer than one cycle");
	a_start_meas: assert property (meas_start |=> s_meas)
		else $error("start did not enter measurement");
	a_start_prep: assert property (meas_start |-> meas_state == CCB_PREP)
		else $error("start pulse outside prepare state");
	a_partial_prep: assert property (partial_reset |=> meas_state == CCB_PREP)
		else $error("partial reset did not prepare");
	a_powerup_clear: assert property (power_up_reset |=> meas_state == CCB_IDLE && !run_bit && config_words == '0)
		else $error("power-up reset left state behind");
	a_reset_clear: assert property ($past(rst) |-> meas_state == CCB_IDLE && !run_bit && config_words == '0)
		else $error("reset values wrong");
	a_ready_meas: assert property (res_ready |-> s_meas)
		else $error("results taken outside measurement");
	// a long selected frame is still incomplete, so nothing may change yet
	a_ready_idle: assert property ((!link_select_n) [*3] |-> !res_ready)
		else $error("results offered while a frame is open");
	a_quiet_frame: assert property ((!link_select_n) [*8] |-> $stable(config_words) && $stable(run_bit) && $stable(meas_state))
		else $error("registers changed inside a frame");
endmodule
bind ccb_interp ccb_sva u_sva (.clk(clk), .rst(rst), .link_select_n(link_select_n), .config_words(config_words),
	.run_bit(run_bit), .power_up_reset(power_up_reset), .partial_reset(partial_reset), .meas_start(meas_start),
	.meas_state(meas_state), .res_ready(res_ready));

/* tb/testbench.sv */
// self-checking bench for the bring-up command interpreter
`timescale 1ns/100ps
module testbench import ccb_pkg::*;;
	logic clk, rst, link_sclk, link_select_n, link_mosi, link_miso, run_bit, rd_stb, sram_rd;
	logic power_up_reset, partial_reset, meas_start, res_valid, res_ready;
	logic [CCB_CFG_COUNT-1:0][23:0] config_words;
	ccb_meas_state_t meas_state;
	ccb_results_t res_in;
	logic [7:0] fw_addr, fw_data, sa[4], sb[4];
	logic [31:0] rd_word;
	logic [23:0] cw[CCB_CFG_COUNT], exp_q[$];
	int failures, total_checks, cycles, k;
	ccb_interp #(.SRAM_AW(8)) dut (.clk(clk), .rst(rst), .link_sclk(link_sclk), .link_select_n(link_select_n),
		.link_mosi(link_mosi), .link_miso(link_miso), .config_words(config_words), .run_bit(run_bit),
		.power_up_reset(power_up_reset), .partial_reset(partial_reset), .meas_start(meas_start),
		.meas_state(meas_state), .res_valid(res_valid), .res_ready(res_ready), .res_in(res_in),
		.fw_addr(fw_addr), .fw_data(fw_data));
	ccb_host host (.link_sclk(link_sclk), .link_select_n(link_select_n), .link_mosi(link_mosi),
		.link_miso(link_miso), .rd_stb(rd_stb), .rd_word(rd_word));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out();
		if (exp_q.size() != 0) failures++;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic cmd(input logic [31:0] w, input int n, input logic rd);
		@(posedge clk);
		#1 host.xfer(w, n, rd);
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [5:0] a, input logic [23:0] e);
		exp_q.push_back(e);
		cmd({CCB_PFX_RES_RD, a, 24'h000000}, 32, 1'b1);
	endtask
	initial forever begin
		@(posedge rd_stb);
		chk("read data", exp_q.pop_front(), sram_rd ? {16'h0000, rd_word[7:0]} : rd_word[23:0]);
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		rst = 1'b1;
		res_valid = 1'b0;
		res_in = '0;
		fw_addr = '0;
		sram_rd = 1'b0;
		cycles = 0;
		failures = 0;
		total_checks = 0;
		void'($urandom(74600));
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		cmd({CCB_OPC_POWER_UP, 24'h000000}, 8, 1'b0);
		sram_rd = 1'b1;
		for (int i = 0; i < 4; i++) begin
			sa[i] = 8'(i * 85);
			sb[i] = 8'($urandom);
			cmd({CCB_PFX_SRAM_WR, 4'h0, sa[i], sb[i], 8'h00}, 24, 1'b0);
		end
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back({16'h0000, sb[i]});
			cmd({CCB_PFX_SRAM_RD, 4'h0, sa[i], 16'h0000}, 24, 1'b1);
			fw_addr = sa[i];
			#1 chk("fetch byte", {16'h0000, sb[i]}, {16'h0000, fw_data});
		end
		sram_rd = 1'b0;
		for (int i = 0; i < CCB_CFG_COUNT; i++) begin
			cw[i] = 24'($urandom);
			cmd({CCB_PFX_CFG_WR, 6'(i), cw[i]}, 32, 1'b0);
		end
		cmd({2'h2, 6'h00, ~cw[0]}, 32, 1'b0);
		cmd({8'h8B, 24'h000000}, 8, 1'b0);
		for (int i = 0; i < CCB_CFG_COUNT; i++) chk("config word", cw[i], config_words[i]);
		chk("state idle", {22'h0, CCB_IDLE}, {22'h0, meas_state});
		cmd({CCB_PFX_CFG_WR, CCB_RUN_CONTROL_ADDR, 24'h000001}, 32, 1'b0);
		chk("run bit", 24'h000001, {23'h0, run_bit});
		cmd({CCB_OPC_PARTIAL, 24'h000000}, 8, 1'b0);
		chk("state prep", {22'h0, CCB_PREP}, {22'h0, meas_state});
		chk("config kept", cw[10], config_words[10]);
		cmd({CCB_OPC_START, 24'h000000}, 8, 1'b0);
		chk("state meas", {22'h0, CCB_MEAS}, {22'h0, meas_state});
		rd(CCB_STATUS_ADDR, 24'h100000);
		res_in = {24'($urandom), 24'($urandom), 24'($urandom)};
		res_valid = 1'b1;
		k = 0;
		while (res_ready !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1 k++;
		end
		@(posedge clk);
		#1 res_valid = 1'b0;
		chk("ready wait", 24'h000000, (k < 50) ? 24'h000000 : 24'h000001);
		rd(CCB_RES_ZERO_ADDR, res_in.discharge_bins);
		rd(CCB_CAP_RATIO_ADDR, res_in.cap_ratio);
		rd(CCB_RES_RATIO_ADDR, res_in.res_ratio);
		rd(CCB_STATUS_ADDR, 24'h900000);
		cmd({CCB_OPC_PARTIAL, 24'h000000}, 8, 1'b0);
		chk("state reprep", {22'h0, CCB_PREP}, {22'h0, meas_state});
		chk("run bit kept", 24'h000001, {23'h0, run_bit});
		rd(CCB_STATUS_ADDR, 24'h000000);
		rd(CCB_CAP_RATIO_ADDR, res_in.cap_ratio);
		rd(6'h05, 24'h000000);
		cmd({CCB_OPC_POWER_UP, 24'h000000}, 8, 1'b0);
		chk("cleared config", 24'h000000, config_words[3]);
		rd(CCB_STATUS_ADDR, 24'h000000);
		rd(CCB_CAP_RATIO_ADDR, 24'h000000);
		cmd({CCB_PFX_CFG_WR, 6'h02, cw[2]}, 32, 1'b0);
		chk("rewrite word", cw[2], config_words[2]);
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		chk("reset config", 24'h000000, config_words[2]);
		repeat (4) @(posedge clk);
		rd(CCB_STATUS_ADDR, 24'h000000);
		close_out();
	end
endmodule
